// file: rtl/cbca_pkg.sv
// constants and carrier types for the bus controller and address former
// assumes one 250 MHz core clock; the bus phases are derived from it
package cbca_pkg;

   // interrupt and reset vectors, low byte; the high byte sits one above
   localparam logic [15:0] VEC_NMI_LO = 16'hFFFA;
   localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
   localparam logic [15:0] VEC_HI_STEP = 16'h0001;

   localparam logic [7:0] STACK_PAGE = 8'h01;
   localparam logic [15:0] ADDR_RESET = 16'hFFFF;

   // processor status layout
   localparam int P_I = 2;
   localparam int P_B = 4;
   localparam int P_ONE = 5;
   localparam int P_V = 6;
   localparam logic [7:0] P_RESET = 8'h20;

   // idle bus cycles after reset release before the vector fetch
   localparam int RST_INIT_CYC = 6;
   localparam logic [2:0] RST_INIT_LAST = 3'(RST_INIT_CYC - 1);
   localparam logic [7:0] SP_PUSH_STEP = 8'h03;

   // ready window figure, unused: a read stalls only on the synchronised ready seen at the one clock of phase two
   localparam int CLK_PERIOD_NS = 4;
   localparam int RDY_WIN_NS = 100;
   localparam int RDY_WIN_CYC = (RDY_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                RDY_WIN_NS / CLK_PERIOD_NS;

   localparam int PIN_W = 13;
   localparam logic [PIN_W-1:0] PIN_IDLE = 13'h1FFF;

   typedef enum logic [2:0] {
      AM_IMM,
      AM_ABS,
      AM_ZP,
      AM_ZP_IDX,
      AM_ABS_IDX
   } cbca_amode_t;

   typedef enum logic [2:0] {
      ST_INIT,
      ST_VEC_LO,
      ST_VEC_HI,
      ST_RUN,
      ST_PUSH_PCH,
      ST_PUSH_PCL,
      ST_PUSH_P
   } cbca_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic fetch;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cbca_req_t;

   typedef struct packed {
      logic valid;
      cbca_amode_t mode;
      logic idx_y;
      logic [7:0] byte2;
      logic [7:0] byte3;
   } cbca_ea_req_t;

   typedef struct packed {
      logic valid;
      logic no_mem;
      logic [15:0] ea;
      logic [7:0] operand;
   } cbca_ea_rsp_t;

endpackage : cbca_pkg

// file: rtl/cbca_bus_ctrl.sv
// bus cycle sequencer, interrupt and reset sequencing, effective address former
// assumes the core side sits on core_clk_i and holds a request until acked;
// pins arrive asynchronously and are synchronised here
module cbca_bus_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   output logic phi2_o,
   output logic [15:0] addr_o,
   output logic rw_o,
   output logic sync_o,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic [7:0] data_i,
   input wire logic data_bus_drive_enable_i,
   input wire logic ready_i,
   input wire logic irq_b_i,
   input wire logic nmi_b_i,
   input wire logic set_overflow_b_i,
   input wire cbca_pkg::cbca_req_t core_req_i,
   input wire logic [15:0] core_pc_i,
   input wire logic [7:0] core_sp_i,
   input wire logic status_we_i,
   input wire logic [7:0] status_wdata_i,
   output logic core_ack_o,
   output logic [7:0] core_rdata_o,
   output logic pc_load_o,
   output logic [15:0] pc_new_o,
   output logic [7:0] sp_new_o,
   output logic [7:0] status_o,
   input wire cbca_pkg::cbca_ea_req_t ea_req_i,
   input wire logic [7:0] idx_x_i,
   input wire logic [7:0] idx_y_i,
   output cbca_pkg::cbca_ea_rsp_t ea_rsp_o
);
   import cbca_pkg::*;

   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [7:0] din_s;
   logic dbe_s;
   logic rdy_s;
   logic irq_b_s;
   logic nmi_b_s;
   logic so_b_s;

   cbca_state_t st;
   cbca_state_t next_st;
   logic [2:0] init_cnt;
   logic [15:0] vec_base;
   logic [7:0] pc_lo;
   logic cur_core;
   logic nmi_prev;
   logic nmi_pend;
   logic irq_lvl;
   logic so_prev;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
      end else begin
         pin_meta <= {data_i, data_bus_drive_enable_i, ready_i, irq_b_i, nmi_b_i,
                      set_overflow_b_i};
         pin_sync <= pin_meta;
      end
   end
   assign {din_s, dbe_s, rdy_s, irq_b_s, nmi_b_s, so_b_s} = pin_sync;

   // phase one while phi2_o is low, phase two while it is high
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phi2_o <= 1'b0;
      end else begin
         phi2_o <= ~phi2_o;
      end
   end

   wire stall = rw_o & ~rdy_s;
   wire adv = phi2_o & ~stall;

   wire int_want = nmi_pend | (irq_lvl & ~status_o[P_I]);
   wire fetch_req = core_req_i.valid & core_req_i.fetch;
   // the core drops its request only after the ack, so a finished request is
   // not taken again while its ack or a new program counter is on its way
   wire core_busy = cur_core | core_ack_o | pc_load_o;
   wire take_int = (st == ST_RUN) & fetch_req & int_want & ~core_busy;
   wire take_core = (st == ST_RUN) & core_req_i.valid & ~take_int & ~core_busy;
   wire [7:0] sp_m1 = core_sp_i - 8'h01;
   wire [7:0] sp_m2 = core_sp_i - 8'h02;
   wire [7:0] p_pushed = (status_o & ~(8'h01 << P_B)) | (8'h01 << P_ONE);

   always_comb begin
      next_st = st;
      unique case (st)
         ST_INIT: begin
            if (init_cnt == RST_INIT_LAST) begin
               next_st = ST_VEC_LO;
            end
         end
         ST_VEC_LO: next_st = ST_VEC_HI;
         ST_VEC_HI: next_st = ST_RUN;
         ST_RUN: begin
            if (take_int) begin
               next_st = ST_PUSH_PCH;
            end
         end
         ST_PUSH_PCH: next_st = ST_PUSH_PCL;
         ST_PUSH_PCL: next_st = ST_PUSH_P;
         ST_PUSH_P: next_st = ST_VEC_LO;
      endcase
   end

   logic [15:0] next_addr;
   logic next_rw;
   logic next_sync;
   logic [7:0] next_wdata;

   always_comb begin
      next_addr = addr_o;
      next_rw = 1'b1;
      next_sync = 1'b0;
      next_wdata = data_o;
      unique case (next_st)
         ST_VEC_LO: next_addr = vec_base;
         ST_VEC_HI: next_addr = vec_base + VEC_HI_STEP;
         ST_RUN: begin
            if (take_core) begin
               next_addr = core_req_i.addr;
               next_rw = ~core_req_i.write;
               next_sync = core_req_i.fetch;
               next_wdata = core_req_i.wdata;
            end
         end
         ST_PUSH_PCH: begin
            next_addr = {STACK_PAGE, core_sp_i};
            next_rw = 1'b0;
            next_wdata = core_pc_i[15:8];
         end
         ST_PUSH_PCL: begin
            next_addr = {STACK_PAGE, sp_m1};
            next_rw = 1'b0;
            next_wdata = core_pc_i[7:0];
         end
         ST_PUSH_P: begin
            next_addr = {STACK_PAGE, sp_m2};
            next_rw = 1'b0;
            next_wdata = p_pushed;
         end
         default: next_addr = addr_o;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= ST_INIT;
         init_cnt <= 3'h0;
         addr_o <= ADDR_RESET;
         rw_o <= 1'b1;
         sync_o <= 1'b0;
         data_o <= 8'h00;
         cur_core <= 1'b0;
      end else if (adv) begin
         st <= next_st;
         init_cnt <= (st == ST_INIT) ? init_cnt + 3'h1 : init_cnt;
         addr_o <= next_addr;
         rw_o <= next_rw;
         sync_o <= next_sync;
         data_o <= next_wdata;
         cur_core <= take_core;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_oe_o <= 1'b0;
      end else begin
         data_oe_o <= ~phi2_o & ~rw_o & dbe_s;
      end
   end

   logic fin_core;
   logic fin_rd;
   logic vlo_cap;
   logic vhi_cap;

   // core answers and vector results; read data is taken one clock after the
   // boundary, since the pin synchroniser delivers the cycle's data that late
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fin_core <= 1'b0;
         fin_rd <= 1'b0;
         vlo_cap <= 1'b0;
         vhi_cap <= 1'b0;
         core_ack_o <= 1'b0;
         core_rdata_o <= 8'h00;
         pc_load_o <= 1'b0;
         pc_new_o <= 16'h0000;
         pc_lo <= 8'h00;
         sp_new_o <= 8'h00;
      end else begin
         fin_core <= adv & cur_core;
         fin_rd <= adv & cur_core & rw_o;
         vlo_cap <= adv & (st == ST_VEC_LO);
         vhi_cap <= adv & (st == ST_VEC_HI);
         core_ack_o <= fin_core;
         pc_load_o <= vhi_cap;
         if (fin_rd) begin
            core_rdata_o <= din_s;
         end
         if (vlo_cap) begin
            pc_lo <= din_s;
         end
         if (vhi_cap) begin
            pc_new_o <= {din_s, pc_lo};
         end
         if (adv & (st == ST_PUSH_P)) begin
            sp_new_o <= core_sp_i - SP_PUSH_STEP;
         end
      end
   end

   // interrupt sampling; a new nmi edge wins over the clear of the old one
   wire smp_int = phi2_o & rdy_s;
   wire nmi_fall = smp_int & nmi_prev & ~nmi_b_s;
   wire int_taken = adv & take_int;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nmi_prev <= 1'b1;
         nmi_pend <= 1'b0;
         irq_lvl <= 1'b0;
         vec_base <= VEC_RST_LO;
      end else begin
         if (smp_int) begin
            nmi_prev <= nmi_b_s;
            irq_lvl <= ~irq_b_s;
         end
         nmi_pend <= nmi_fall | (nmi_pend & ~int_taken);
         if (int_taken) begin
            vec_base <= nmi_pend ? VEC_NMI_LO : VEC_IRQ_LO;
         end
      end
   end

   // overflow edge sampled at the last clock of phase one
   wire so_fall = ~phi2_o & so_prev & ~so_b_s;
   wire mask_set = adv & (next_st == ST_VEC_LO);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         so_prev <= 1'b1;
         status_o <= P_RESET;
      end else begin
         if (!phi2_o) begin
            so_prev <= so_b_s;
         end
         status_o <= status_we_i ? status_wdata_i : status_o;
         if (so_fall) begin
            status_o[P_V] <= 1'b1;
         end
         if (mask_set) begin
            status_o[P_I] <= 1'b1;
         end
      end
   end

   // effective address former, one clock of latency
   wire [7:0] ea_idx = ea_req_i.idx_y ? idx_y_i : idx_x_i;
   wire [15:0] ea_base = {ea_req_i.byte3, ea_req_i.byte2};
   wire [7:0] ea_zp_sum = ea_req_i.byte2 + ea_idx;
   wire [15:0] ea_abs_sum = ea_base + {8'h00, ea_idx};
   logic [15:0] next_ea;
   logic next_no_mem;

   always_comb begin
      next_no_mem = 1'b0;
      unique case (ea_req_i.mode)
         AM_IMM: begin
            next_ea = 16'h0000;
            next_no_mem = 1'b1;
         end
         AM_ABS: next_ea = ea_base;
         AM_ZP: next_ea = {8'h00, ea_req_i.byte2};
         AM_ZP_IDX: next_ea = {8'h00, ea_zp_sum};
         AM_ABS_IDX: next_ea = ea_abs_sum;
         default: next_ea = ea_base;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ea_rsp_o <= '0;
      end else begin
         ea_rsp_o.valid <= ea_req_i.valid;
         ea_rsp_o.no_mem <= next_no_mem;
         ea_rsp_o.ea <= next_ea;
         ea_rsp_o.operand <= ea_req_i.byte2;
      end
   end

   oe_dbe_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      data_oe_o |-> $past(dbe_s) && !phi2_o == 1'b0)
      else $error("data drivers on without drive enable");

   read_oe_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      rw_o |-> !data_oe_o)
      else $error("data drivers on in a read cycle");

   ready_stall_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (phi2_o && rw_o && !rdy_s) |=> $stable(addr_o) && $stable(rw_o) ##1 $stable(addr_o))
      else $error("address moved during ready stall");

   write_no_stall_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (phi2_o && !rw_o && cur_core) |=> ##1 core_ack_o)
      else $error("write cycle was held by ready");

   nmi_vector_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (adv && take_int && nmi_pend) |-> ##7 (addr_o == VEC_NMI_LO && st == ST_VEC_LO))
      else $error("nmi sequence did not reach its vector");

   mask_on_vec_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st == ST_VEC_LO) |-> status_o[P_I])
      else $error("mask flag clear at vector fetch");

   masked_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (take_int && !nmi_pend) |-> !status_o[P_I])
      else $error("maskable request taken while masked");

   so_sets_v_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      so_fall |=> status_o[P_V])
      else $error("overflow flag not set by input edge");

   zp_wrap_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (ea_req_i.valid && ea_req_i.mode == AM_ZP_IDX) |=> ea_rsp_o.ea[15:8] == 8'h00)
      else $error("indexed zero page left page zero");

   init_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st == ST_INIT) |-> rw_o && !core_ack_o && !pc_load_o)
      else $error("transfer during reset initialisation");

endmodule // cbca_bus_ctrl

// file: tb/cbca_mem_model.sv
// memory and peripheral model on the far side of the system bus
// assumes a bus cycle ends at the clock edge that closes phase two
module cbca_mem_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic phi2_i,
   input wire logic [15:0] addr_i,
   input wire logic rw_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [15:0]];
   logic [7:0] last = 8'h00;

   // unwritten places answer with a pattern derived from the address
   function automatic logic [7:0] rd(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
   endfunction

   // a released bus must not keep the last value, so show its inverse
   assign rdata_o = rw_i ? rd(addr_i) : ~last;
   // slow device holds a read cycle for as long as the bench asks
   assign ready_o = !slow_i;

   always @(posedge clk_i) begin
      if (phi2_i && !rw_i) mem[addr_i] = wdata_i;
      if (phi2_i && rw_i) last <= rd(addr_i);
   end
endmodule // cbca_mem_model

// file: tb/tb_top.sv
// self-checking bench: reset, bus cycles, stalls, interrupts, address former
// assumes the memory model answers reads and records every write
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cbca_pkg::*;
   typedef struct packed {logic [15:0] a; logic f; logic r; logic [7:0] d;} cbca_bexp_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic slow = 1'b0;
   logic dbe = 1'b1;
   logic irq_b = 1'b1;
   logic nmi_b = 1'b1;
   logic so_b = 1'b1;
   logic st_we = 1'b0;
   logic [7:0] st_wd = 8'h20;
   logic [7:0] ix = 8'h00;
   logic [7:0] iy = 8'h00;
   logic [7:0] sp = 8'hFF;
   logic [15:0] pc = 16'h0000;
   cbca_req_t req = '0;
   cbca_ea_req_t eareq = '0;
   cbca_ea_rsp_t earsp;
   logic phi2, rw, sync, oe, ack, pcld, ready, last_s;
   logic [15:0] addr, pcnew, last_a;
   logic [7:0] dout, rdata, spnew, status, din, mdata;
   logic [31:0] seed = 32'd90;
   int n_errors = 0;
   int check_count = 0;
   int oe_cnt = 0;
   cbca_bexp_t q_bus[$];
   cbca_bexp_t be;
   logic [15:0] q_pc[$];
   logic [24:0] q_ea[$];
   logic [24:0] ee;

   cbca_bus_ctrl dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .phi2_o(phi2), .addr_o(addr),
      .rw_o(rw), .sync_o(sync), .data_o(dout), .data_oe_o(oe), .data_i(din),
      .data_bus_drive_enable_i(dbe), .ready_i(ready), .irq_b_i(irq_b), .nmi_b_i(nmi_b),
      .set_overflow_b_i(so_b), .core_req_i(req), .core_pc_i(pc), .core_sp_i(sp),
      .status_we_i(st_we), .status_wdata_i(st_wd), .core_ack_o(ack), .core_rdata_o(rdata),
      .pc_load_o(pcld), .pc_new_o(pcnew), .sp_new_o(spnew), .status_o(status),
      .ea_req_i(eareq), .idx_x_i(ix), .idx_y_i(iy), .ea_rsp_o(earsp));
   cbca_mem_model mem_u (.clk_i(clk), .slow_i(slow), .phi2_i(phi2), .addr_i(addr),
      .rw_i(rw), .wdata_i(dout), .rdata_o(mdata), .ready_o(ready));
   // wire level of the shared data lines
   assign din = oe ? dout : mdata;

   always #2 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   always @(posedge clk) if (phi2) begin
      last_a <= addr;
      last_s <= sync;
   end

   always @(negedge clk) begin
      if (oe === 1'b1) oe_cnt++;
      if (rw === 1'b1) chk("oe in read", oe, 1'b0);
      if (ack === 1'b1) begin
         be = q_bus.pop_front();
         chk("cycle addr", last_a, be.a);
         chk("fetch marker", last_s, be.f);
         if (be.r) chk("read data", rdata, be.d);
      end
      if (pcld === 1'b1) begin
         chk("vector pending", q_pc.size() > 0, 1'b1);
         if (q_pc.size() > 0) chk("vector", pcnew, q_pc.pop_front());
      end
      if (earsp.valid === 1'b1) begin
         ee = q_ea.pop_front();
         chk("ea", {earsp.no_mem, earsp.ea}, ee[24:8]);
         if (ee[24]) chk("operand", earsp.operand, ee[7:0]);
      end
   end

   task automatic bus(input logic w, f, input logic [15:0] a, input logic [7:0] d, input logic st);
      int k;
      k = 0;
      q_bus.push_back({a, f, !w, w ? 8'h00 : mem_u.rd(a)});
      @(posedge clk);
      req <= '{1'b1, w, f, a, d};
      slow <= st;
      if (st && !w) begin
         repeat (20) begin
            @(negedge clk);
            chk("held ack", ack, 1'b0);
         end
         chk("held addr", addr, a);
         @(posedge clk);
         slow <= 1'b0;
      end
      do @(negedge clk); while (ack !== 1'b1 && k++ < 100);
      chk("ack seen", ack, 1'b1);
      @(posedge clk);
      req.valid <= 1'b0;
      slow <= 1'b0;
   endtask

   task automatic ea(input cbca_amode_t m, input logic y);
      logic [7:0] b2, b3, i;
      logic [15:0] e;
      b2 = 8'(xs());
      b3 = 8'(xs());
      i = 8'(xs());
      case (m)
         AM_IMM: e = 16'h0000;
         AM_ABS: e = {b3, b2};
         AM_ZP: e = {8'h00, b2};
         AM_ZP_IDX: e = {8'h00, 8'(b2 + i)};
         default: e = {b3, b2} + {8'h00, i};
      endcase
      q_ea.push_back({m == AM_IMM, e, b2});
      @(posedge clk);
      if (y) iy <= i;
      else ix <= i;
      eareq <= '{1'b1, m, y, b2, b3};
      @(posedge clk);
      eareq.valid <= 1'b0;
   endtask

   task automatic int_seq(input logic [15:0] v, input logic [7:0] ps);
      int k;
      logic [7:0] s;
      k = 0;
      s = 8'(xs()) | 8'h10;
      q_pc.push_back({mem_u.rd(v + 16'h0001), mem_u.rd(v)});
      @(posedge clk);
      sp <= s;
      pc <= 16'(xs());
      req <= '{1'b1, 1'b0, 1'b1, 16'h0400, 8'h00};
      do @(negedge clk); while (pcld !== 1'b1 && k++ < 200);
      chk("int vector load", pcld, 1'b1);
      @(posedge clk);
      req.valid <= 1'b0;
      @(negedge clk);
      chk("new sp", spnew, 8'(s - 3));
      chk("push pc hi", mem_u.rd({8'h01, s}), pc[15:8]);
      chk("push pc lo", mem_u.rd({8'h01, 8'(s - 1)}), pc[7:0]);
      chk("push status", mem_u.rd({8'h01, 8'(s - 2)}) & 8'h34, ps);
      chk("mask set", status[2], 1'b1);
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      summarize();
   end

   initial begin
      int k, c;
      logic [15:0] a;
      logic [7:0] d;
      k = 0;
      q_pc.push_back({mem_u.rd(16'hFFFD), mem_u.rd(16'hFFFC)});
      repeat (8) @(negedge clk);
      chk("rw in reset", rw, 1'b1);
      chk("oe in reset", oe, 1'b0);
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      do @(negedge clk); while (pcld !== 1'b1 && k++ < 200);
      chk("reset vector load", pcld, 1'b1);
      chk("init length", k >= 12, 1'b1);
      chk("mask after reset", status[2], 1'b1);
      $display("reset test done");
      for (int m = 0; m < 5; m++)
         for (int y = 0; y < 2; y++) ea(cbca_amode_t'(m), y[0]);
      $display("address test done");
      for (int i = 0; i < 6; i++) begin
         a = 16'h0200 | {8'h00, 8'(xs())};
         d = 8'(xs());
         bus(1'b1, 1'b0, a, d, i[1]);
         bus(1'b0, i[0], a, 8'h00, i[1] & i[0]);
         chk("read back", rdata, d);
      end
      bus(1'b0, 1'b1, 16'h0300, 8'h00, 1'b1);
      c = oe_cnt;
      @(posedge clk);
      dbe <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b1, 1'b0, 16'h0280, 8'hA5, 1'b0);
      chk("oe while disabled", oe_cnt, c);
      @(posedge clk);
      dbe <= 1'b1;
      bus(1'b1, 1'b0, 16'h0281, 8'h5A, 1'b0);
      chk("oe while enabled", oe_cnt > c, 1'b1);
      $display("bus test done");
      @(posedge clk);
      irq_b <= 1'b0;
      bus(1'b0, 1'b1, 16'h0300, 8'h00, 1'b0);
      @(posedge clk);
      st_we <= 1'b1;
      @(posedge clk);
      st_we <= 1'b0;
      int_seq(VEC_IRQ_LO, 8'h20);
      irq_b <= 1'b1;
      @(posedge clk);
      nmi_b <= 1'b0;
      repeat (4) @(posedge clk);
      nmi_b <= 1'b1;
      int_seq(VEC_NMI_LO, 8'h24);
      $display("interrupt test done");
      @(posedge clk);
      st_we <= 1'b1;
      @(posedge clk);
      st_we <= 1'b0;
      repeat (4) @(negedge clk);
      chk("overflow clear", status[6], 1'b0);
      @(posedge clk);
      so_b <= 1'b0;
      repeat (4) @(posedge clk);
      so_b <= 1'b1;
      repeat (4) @(negedge clk);
      chk("overflow set", status[6], 1'b1);
      $display("overflow test done");
      summarize();
   end
endmodule // tb_top
